/* File: pm_vpd_defines.svh */
/*
  Offsets, field positions, reset values and fixed codes of the power
  management and product data capability structures.
  Assumes byte addresses in configuration space; included by its bare name.
*/
`ifndef PM_VPD_DEFINES_SVH
`define PM_VPD_DEFINES_SVH

// Configuration space dword offsets (byte addresses)
`define PM_CAP_OFS 8'h40
`define PM_CTRL_OFS 8'h44
`define VPD_CAP_OFS 8'h48
`define PRODUCT_DATA_WORD_OFS 8'h4C

// Capability identifiers
`define PM_CAP_ID 8'h01
`define VPD_CAP_ID 8'h03

// Fixed capabilities word fields
`define PMC_EVENT_STATES 5'h09
`define PMC_STATE_TWO 1'b0
`define PMC_STATE_ONE 1'b0
`define PMC_AUX_CURRENT 3'h0
`define PMC_SPECIAL_INIT 1'b0
`define PMC_RESERVED4 1'b0
`define PMC_NEEDS_CLOCK 1'b1
`define PMC_REVISION 3'h2

// Control/status word field positions
`define PMCS_STATUS_BIT 15
`define PMCS_SCALE_HI 14
`define PMCS_SCALE_LO 13
`define PMCS_SEL_HI 12
`define PMCS_SEL_LO 9
`define PMCS_ENABLE_BIT 8

// Product data address register field positions (within upper half)
`define VPD_FLAG_BIT 31
`define VPD_ADDR_HI 30
`define VPD_ADDR_LO 16

// Reset values
`define BRIDGE_EXT_RESET 8'h00
`define VPD_WORD_RESET 32'h0000_0000
`define VPD_ADDR_RESET 15'h0000
`define SEL_RESET 4'h0

// Highest boot configuration byte held in the shared EEPROM
`define BOOT_AREA_END 8'h30

`endif

/* File: pm_vpd_pkg.sv */
/*
  Types shared by the power management and product data capability block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pm_vpd_pkg;

  // Product data fetch sequencer, one-hot
  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b01,
    FETCH_BUSY = 2'b10
  } fetch_state_t;

  // Power state field encoding
  typedef enum logic [1:0] {
    PS_D0 = 2'b00,
    PS_D1 = 2'b01,
    PS_D2 = 2'b10,
    PS_D3 = 2'b11
  } power_state_t;

endpackage

/* File: pm_vpd_capabilities.sv */
/*
  Power management and product data capability structures of a PCI target,
  with the power event pin logic and the EEPROM fetch sequencer.
  Assumes a configuration access port on the PCI clock, an EEPROM reader on
  the same clock that answers a word request, and boot load values on the
  same clock. The power event request input is asynchronous.

// Summary of operation
// - Next pointers read-only, zero at list end
// - Event support field reads 01001b
// - D1 and State_two_supported bits read zero
// - Auxiliary current field reads zero
// - Special init zero, needs-clock one, bit4 reserved
// - Event status set on event, write-one clears
// - Data scale read-only from boot load
// - Select picks consumed or dissipated power
// - Data byte read-only, scaled by scale code
// - Event enable gates event pin, resets zero
// - Power state D0/D3 only, D1/D2 writes ignored
// - Bridge extension byte reads zero
// - Event pin is open drain, low asserts
// - Rising request with enable sets status
// - Power state output shows D0 or D3
// - Product data identifier reads 03h
// - Product data writes never reach EEPROM
// - Address write with flag zero starts fetch
// - Data register holds fetched dword
// - Product data lies above boot area
// - Product data capability at 48h to 4Fh
// - Power capability at 40h to 47h
// - Power capability identifier reads 01h
*/
`timescale 1ns/1ns
`include "pm_vpd_defines.svh"

module pm_vpd_capabilities #(
  parameter logic [7:0] PM_NEXT_PTR = `VPD_CAP_OFS,
  parameter logic [7:0] VPD_NEXT_PTR = 8'h00,
  parameter logic [17:0] VPD_BASE = 18'h00034,
  parameter logic STATE_OUT_D0_LEVEL = 1'b1
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic cfg_sel_i,
  input wire logic cfg_we_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  input wire logic [1:0] boot_data_scale_i,
  input wire logic [63:0] boot_power_readings_i,
  input wire logic power_event_request_in_i,
  output logic pme_n_o,
  output logic pme_oe_n_o,
  output logic power_state_out_o,
  output logic rom_req_o,
  output logic [17:0] rom_addr_o,
  input wire logic rom_ack_i,
  input wire logic [31:0] rom_data_i
);

  // Product data must sit above the boot configuration area, word aligned
  generate
    if (VPD_BASE <= {10'h000, `BOOT_AREA_END} || VPD_BASE[1:0] != 2'b00) begin : g_base_chk
      $error("VPD_BASE must be word aligned and above the boot area");
    end
  endgenerate

  // Byte lane merge of a write into a register image
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Access decode
  logic wr_pm_ctrl;
  logic wr_vpd_cap;
  logic [31:0] pm_ctrl_wr_img;
  logic [31:0] vpd_cap_wr_img;

  // Control state
  logic power_event_status_reg;
  logic power_event_status_next;
  logic pme_enable_reg;
  logic pme_enable_next;
  logic [3:0] data_sel_reg;
  logic [3:0] data_sel_next;
  pm_vpd_pkg::power_state_t pstate_reg;
  pm_vpd_pkg::power_state_t pstate_next;

  // Event input synchroniser and edge detector
  logic req_meta_reg;
  logic req_sync_reg;
  logic req_prev_reg;
  logic req_rise;

  // Fetch sequencer state
  pm_vpd_pkg::fetch_state_t fetch_reg;
  pm_vpd_pkg::fetch_state_t fetch_next;
  logic [14:0] vpd_addr_reg;
  logic [14:0] vpd_addr_next;
  logic vpd_flag_reg;
  logic vpd_flag_next;
  logic [31:0] vpd_word_reg;
  logic [31:0] vpd_word_next;

  // Read path
  logic [31:0] rdata_next;
  logic [15:0] pm_caps;
  logic [15:0] pm_ctrl_word;
  logic [7:0] power_reading;

  // Write strobes for the writable dwords; misaligned and other writes are ignored
  assign wr_pm_ctrl = cfg_sel_i && cfg_we_i && (cfg_addr_i == `PM_CTRL_OFS);
  assign wr_vpd_cap = cfg_sel_i && cfg_we_i && (cfg_addr_i == `VPD_CAP_OFS);
  assign pm_ctrl_wr_img = lane_merge(32'h0000_0000, cfg_wdata_i, cfg_be_i);
  assign vpd_cap_wr_img = lane_merge({vpd_flag_reg, vpd_addr_reg, 16'h0000}, cfg_wdata_i,
                                     cfg_be_i);

  // Fixed capabilities word
  assign pm_caps = {`PMC_EVENT_STATES, `PMC_STATE_TWO, `PMC_STATE_ONE,
                    `PMC_AUX_CURRENT, `PMC_SPECIAL_INIT, `PMC_RESERVED4,
                    `PMC_NEEDS_CLOCK, `PMC_REVISION};

  // Live control/status word; scale comes straight from the boot load
  assign pm_ctrl_word = {power_event_status_reg, boot_data_scale_i, data_sel_reg,
                         pme_enable_reg, 6'h00, pstate_reg};

  // Reading selected by the select field, reserved codes read zero
  always_comb begin
    if (data_sel_reg[3]) begin
      power_reading = 8'h00;
    end else begin
      power_reading = boot_power_readings_i[data_sel_reg[2:0]*8 +: 8];
    end
  end

  // Power event request: two flops then edge detect
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      req_prev_reg <= 1'b0;
    end else begin
      req_meta_reg <= power_event_request_in_i;
      req_sync_reg <= req_meta_reg;
      req_prev_reg <= req_sync_reg;
    end
  end

  assign req_rise = req_sync_reg && !req_prev_reg;

  // Next values of the power management control fields
  always_comb begin
    power_event_status_next = power_event_status_reg;
    pme_enable_next = pme_enable_reg;
    data_sel_next = data_sel_reg;
    pstate_next = pstate_reg;
    if (wr_pm_ctrl) begin
      if (cfg_be_i[1]) begin
        if (pm_ctrl_wr_img[`PMCS_STATUS_BIT]) begin
          power_event_status_next = 1'b0;
        end
        data_sel_next = pm_ctrl_wr_img[`PMCS_SEL_HI:`PMCS_SEL_LO];
        pme_enable_next = pm_ctrl_wr_img[`PMCS_ENABLE_BIT];
      end
      if (cfg_be_i[0]) begin
        // Only D0 and D3 are accepted
        if (pm_ctrl_wr_img[1:0] == pm_vpd_pkg::PS_D0) begin
          pstate_next = pm_vpd_pkg::PS_D0;
        end else if (pm_ctrl_wr_img[1:0] == pm_vpd_pkg::PS_D3) begin
          pstate_next = pm_vpd_pkg::PS_D3;
        end
      end
    end
    // A request edge wins over a clear in the same cycle
    if (req_rise && pme_enable_reg) begin
      power_event_status_next = 1'b1;
    end
  end

  // Power management control registers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      power_event_status_reg <= 1'b0;
      pme_enable_reg <= 1'b0;
      data_sel_reg <= `SEL_RESET;
      pstate_reg <= pm_vpd_pkg::PS_D0;
    end else begin
      power_event_status_reg <= power_event_status_next;
      pme_enable_reg <= pme_enable_next;
      data_sel_reg <= data_sel_next;
      pstate_reg <= pstate_next;
    end
  end

  // Event pin: data always low, driven only while status and enable stand
  assign pme_n_o = 1'b0;
  assign pme_oe_n_o = !(power_event_status_reg && pme_enable_reg);

  // Power state level for the local device
  assign power_state_out_o = (pstate_reg == pm_vpd_pkg::PS_D3) ? !STATE_OUT_D0_LEVEL
                                                               : STATE_OUT_D0_LEVEL;

  // Next values of the product data fetch sequencer
  always_comb begin
    fetch_next = fetch_reg;
    vpd_addr_next = vpd_addr_reg;
    vpd_flag_next = vpd_flag_reg;
    vpd_word_next = vpd_word_reg;
    case (fetch_reg)
      pm_vpd_pkg::FETCH_IDLE: begin
        fetch_next = pm_vpd_pkg::FETCH_IDLE;
      end
      pm_vpd_pkg::FETCH_BUSY: begin
        if (rom_ack_i) begin
          vpd_word_next = rom_data_i;
          vpd_flag_next = 1'b1;
          fetch_next = pm_vpd_pkg::FETCH_IDLE;
        end
      end
      default: begin
        fetch_next = pm_vpd_pkg::FETCH_IDLE;
      end
    endcase
    // Address write with flag clear starts or restarts a fetch
    if (wr_vpd_cap && cfg_be_i[3] && !vpd_cap_wr_img[`VPD_FLAG_BIT]) begin
      vpd_addr_next = vpd_cap_wr_img[`VPD_ADDR_HI:`VPD_ADDR_LO];
      vpd_flag_next = 1'b0;
      vpd_word_next = vpd_word_reg;
      fetch_next = pm_vpd_pkg::FETCH_BUSY;
    end
  end

  // Product data registers; writes with flag set are ignored
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fetch_reg <= pm_vpd_pkg::FETCH_IDLE;
      vpd_addr_reg <= `VPD_ADDR_RESET;
      vpd_flag_reg <= 1'b0;
      vpd_word_reg <= `VPD_WORD_RESET;
    end else begin
      fetch_reg <= fetch_next;
      vpd_addr_reg <= vpd_addr_next;
      vpd_flag_reg <= vpd_flag_next;
      vpd_word_reg <= vpd_word_next;
    end
  end

  // EEPROM word request, read only, above the boot area
  assign rom_req_o = (fetch_reg == pm_vpd_pkg::FETCH_BUSY);
  assign rom_addr_o = VPD_BASE + {1'b0, vpd_addr_reg, 2'b00};

  // Read data selection by dword offset
  always_comb begin
    case (cfg_addr_i)
      `PM_CAP_OFS: begin
        rdata_next = {pm_caps, PM_NEXT_PTR, `PM_CAP_ID};
      end
      `PM_CTRL_OFS: begin
        rdata_next = {power_reading, `BRIDGE_EXT_RESET, pm_ctrl_word};
      end
      `VPD_CAP_OFS: begin
        rdata_next = {vpd_flag_reg, vpd_addr_reg, VPD_NEXT_PTR, `VPD_CAP_ID};
      end
      `PRODUCT_DATA_WORD_OFS: begin
        rdata_next = vpd_word_reg;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
    if (cfg_addr_i[1:0] != 2'b00) begin
      rdata_next = 32'h0000_0000;
    end
  end

  // Registered answer, one cycle after the access
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_ack_o <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
    end else begin
      cfg_ack_o <= cfg_sel_i;
      if (cfg_sel_i && !cfg_we_i) begin
        cfg_rdata_o <= rdata_next;
      end
    end
  end

endmodule

/* File: pm_vpd_chk.sv */
/* Port checker for the capability block.
   Assumes a bind onto pm_vpd_capabilities. */
`timescale 1ns/1ns
module pm_vpd_chk #(
  parameter logic [17:0] VPD_BASE = 18'h00034
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic cfg_sel_i,
  input wire logic cfg_we_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic cfg_ack_o,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic pme_n_o,
  input wire logic rom_req_o,
  input wire logic [17:0] rom_addr_o,
  input wire logic rom_ack_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic rd, w48, go;
  logic [17:0] wa;
  // Decoded access kinds
  assign rd = cfg_sel_i && !cfg_we_i;
  assign w48 = cfg_sel_i && cfg_we_i && cfg_addr_i == 8'h48;
  assign go = w48 && cfg_be_i[3] && cfg_be_i[2] && !cfg_wdata_i[31];
  assign wa = {1'b0, cfg_wdata_i[30:16], 2'b00};
  property p_ack; cfg_sel_i |=> cfg_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_quiet; !cfg_sel_i |=> !cfg_ack_o; endproperty
  a_quiet: assert property (p_quiet) else $error("stray ack");
  property p_pm_hdr; rd && cfg_addr_i == 8'h40 |=> cfg_rdata_o == 32'h480A_4801; endproperty
  a_pm_hdr: assert property (p_pm_hdr) else $error("pm header");
  property p_vpd_hdr; rd && cfg_addr_i == 8'h48 |=> cfg_rdata_o[15:0] == 16'h0003; endproperty
  a_vpd_hdr: assert property (p_vpd_hdr) else $error("vpd header");
  property p_pm_ctl; rd && cfg_addr_i == 8'h44 |=> cfg_rdata_o[23:16] == 8'h00; endproperty
  a_pm_ctl: assert property (p_pm_ctl) else $error("bridge byte");
  property p_pin; pme_n_o == 1'b0; endproperty
  a_pin: assert property (p_pin) else $error("pin data");
  property p_start; go |=> rom_req_o && rom_addr_o == VPD_BASE + $past(wa); endproperty
  a_start: assert property (p_start) else $error("fetch start");
  property p_area; rom_req_o |-> rom_addr_o > 18'h00030; endproperty
  a_area: assert property (p_area) else $error("boot area");
  property p_done; rom_req_o && rom_ack_i && !w48 |=> !rom_req_o; endproperty
  a_done: assert property (p_done) else $error("fetch end");
endmodule

/* File: rom_model.sv */
/* EEPROM word reader on the far side of the fetch port.
   Assumes the block's clock; answers lat_i + 1 cycles after a request. */
`timescale 1ns/1ns
module rom_model (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic rom_req_i,
  input wire logic [17:0] rom_addr_i,
  input wire logic [3:0] lat_i,
  output logic rom_ack_o,
  output logic [31:0] rom_data_o
);
  logic [3:0] cnt;
  // Read-only store, one answer per request, no write path
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 4'h0;
      rom_ack_o <= 1'b0;
      rom_data_o <= 32'h0000_0000;
    end else if (rom_req_i && !rom_ack_o && cnt >= lat_i) begin
      cnt <= 4'h0;
      rom_ack_o <= 1'b1;
      rom_data_o <= {rom_addr_i[17:2], ~rom_addr_i[17:2]};
    end else begin
      cnt <= rom_req_i ? cnt + 4'h1 : 4'h0;
      rom_ack_o <= 1'b0;
      rom_data_o <= ~rom_data_o; // Stale data never holds
    end
  end
endmodule

/* File: pci_pm_vpd_capabilities_bench.sv */
/* Self-checking bench for the capability block.
   Assumes the checker and EEPROM model compile first. */
`timescale 1ns/1ns
module pci_pm_vpd_capabilities_bench;
  logic mclk_i = 1'b0, rstn_i = 1'b0, sel = 1'b0, we = 1'b0, ev = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'h0, lat = 4'h0;
  logic [31:0] wd = 32'h0, rd, rdat, rom_data;
  logic [1:0] scale = 2'h0;
  logic [63:0] pw = 64'h0;
  logic [14:0] a;
  logic [31:0] ex;
  logic ack, pme_n, pme_oe_n, ps_out, rom_req, rom_ack;
  logic [17:0] rom_addr;
  integer seed = 70864, n_fail = 0, cmp_count = 0, cyc = 0, i, st;
  pm_vpd_capabilities dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .cfg_sel_i(sel),
    .cfg_we_i(we), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wd),
    .cfg_ack_o(ack), .cfg_rdata_o(rdat), .boot_data_scale_i(scale),
    .boot_power_readings_i(pw), .power_event_request_in_i(ev), .pme_n_o(pme_n),
    .pme_oe_n_o(pme_oe_n), .power_state_out_o(ps_out), .rom_req_o(rom_req),
    .rom_addr_o(rom_addr), .rom_ack_i(rom_ack), .rom_data_i(rom_data));
  rom_model u_rom (.mclk_i(mclk_i), .rstn_i(rstn_i), .rom_req_i(rom_req),
    .rom_addr_i(rom_addr), .lat_i(lat), .rom_ack_o(rom_ack), .rom_data_o(rom_data));
  // Clock and hang limit
  initial forever #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      summarize;
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One config access, answer taken one cycle later
  task cfg(input logic w, input logic [7:0] ad, input logic [3:0] b, input logic [31:0] d);
    @(posedge mclk_i);
    sel <= 1'b1;
    we <= w;
    addr <= ad;
    be <= b;
    wd <= d;
    @(posedge mclk_i);
    sel <= 1'b0;
    #1;
    chk("ack", 32'h1, ack);
    rd = rdat;
  endtask
  // Poll the flag, then compare address and fetched word
  task fetch(input logic [14:0] ad);
    integer k;
    logic [17:0] ba;
    ba = 18'h00034 + {1'b0, ad, 2'b00};
    k = 0;
    rd = 32'h0;
    while (rd[31] !== 1'b1 && k < 40) begin
      cfg(1'b0, 8'h48, 4'h0, 32'h0);
      if (k == 0 && lat != 4'h0) chk("flag_busy", 32'h0, rd[31]);
      k++;
    end
    chk("vpd_addr", {1'b1, ad, 16'h0003}, rd);
    cfg(1'b0, 8'h4C, 4'h0, 32'h0);
    chk("product_data_word", {ba[17:2], ~ba[17:2]}, rd);
  endtask
  initial begin
    scale <= 2'($random(seed));
    pw <= {$random(seed), $random(seed)};
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
    // Fixed words, writes ignored, unmapped reads zero
    cfg(1'b1, 8'h40, 4'hF, 32'hFFFF_FFFF);
    cfg(1'b0, 8'h40, 4'h0, 32'h0);
    chk("pm_hdr", 32'h480A_4801, rd);
    cfg(1'b0, 8'h48, 4'h0, 32'h0);
    chk("vpd_hdr", 32'h0000_0003, rd);
    cfg(1'b0, 8'h4C, 4'h0, 32'h0);
    chk("vpd_word", 32'h0, rd);
    cfg(1'b0, 8'h41, 4'h0, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Reading select sweep
    for (i = 0; i < 16; i++) begin
      cfg(1'b1, 8'h44, 4'h2, i << 9);
      cfg(1'b0, 8'h44, 4'h0, 32'h0);
      ex = {i < 8 ? pw[8*i +: 8] : 8'h00, 9'h000, scale, i[3:0], 9'h000};
      chk("pm_ctl", ex, rd);
    end
    // Power states, middle codes ignored
    st = 0;
    for (i = 0; i < 4; i++) begin
      cfg(1'b1, 8'h44, 4'h1, 3 - i);
      if (i == 0 || i == 3) st = 3 - i;
      cfg(1'b0, 8'h44, 4'h0, 32'h0);
      chk("pstate", st, rd[1:0]);
      chk("ps_out", st == 0, ps_out);
    end
    // Event dropped while disabled, then raised and cleared
    cfg(1'b1, 8'h44, 4'h2, 32'h0);
    @(posedge mclk_i) ev <= 1'b1;
    repeat (6) @(posedge mclk_i);
    cfg(1'b0, 8'h44, 4'h0, 32'h0);
    chk("stat_off", 32'h0, rd[15]);
    chk("oe_off", 32'h1, pme_oe_n);
    @(posedge mclk_i) ev <= 1'b0;
    cfg(1'b1, 8'h44, 4'h2, 32'h100);
    @(posedge mclk_i) ev <= 1'b1;
    repeat (6) @(posedge mclk_i);
    cfg(1'b0, 8'h44, 4'h0, 32'h0);
    chk("stat_on", 32'h1, rd[15]);
    chk("oe_on", 32'h0, pme_oe_n);
    cfg(1'b1, 8'h44, 4'h2, 32'h8100);
    cfg(1'b0, 8'h44, 4'h0, 32'h0);
    chk("stat_clr", 32'h0, rd[15]);
    chk("oe_clr", 32'h1, pme_oe_n);
    // Fetches, fast and slow, one restarted mid-fetch
    for (i = 0; i < 6; i++) begin
      a = 15'($random(seed));
      lat <= i[0] ? 4'h8 : 4'h0;
      cfg(1'b1, 8'h48, 4'hC, {1'b0, a, 16'h0});
      if (i == 3) begin
        a = a ^ 15'h0001;
        cfg(1'b1, 8'h48, 4'hC, {1'b0, a, 16'h0});
      end
      fetch(a);
    end
    // Product data writes change nothing
    lat <= 4'h0; // Flag stays set, so no busy poll is expected
    cfg(1'b1, 8'h48, 4'hC, 32'hFFFF_0000);
    cfg(1'b1, 8'h4C, 4'hF, 32'h1234_5678);
    chk("req_idle", 32'h0, rom_req);
    fetch(a);
    summarize;
  end
endmodule
bind pm_vpd_capabilities pm_vpd_chk #(.VPD_BASE(VPD_BASE)) chk (.mclk_i(mclk_i),
  .rstn_i(rstn_i), .cfg_sel_i(cfg_sel_i), .cfg_we_i(cfg_we_i), .cfg_addr_i(cfg_addr_i),
  .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_ack_o(cfg_ack_o),
  .cfg_rdata_o(cfg_rdata_o), .pme_n_o(pme_n_o), .rom_req_o(rom_req_o),
  .rom_addr_o(rom_addr_o), .rom_ack_i(rom_ack_i));
